// [bench/pmsnap_bank_tb.sv]
`timescale 1ns/1ps

module pmsnap_bank_tb;
    logic sys_clk, resetn, go, ext_req_pin, sec_v, pwr, dl, ack, err, nc;
    logic [31:0] rdata;
    pmsnap_pkg::pmsnap_live_s live, cap;
    pmsnap_pkg::pmsnap_req_s req;
    int failures, n_compared, seed;

    // ****************************************************
    // instances
    // ****************************************************
    pmsnap_dbg dbg (.sys_clk(sys_clk), .go(go), .ext_req_pin(ext_req_pin));
    pmsnap_bank dut (.sys_clk(sys_clk), .resetn(resetn), .ce(1'b1), .ext_req_pin(ext_req_pin),
        .live(live), .sec_violation(sec_v), .core_pwr_off(pwr), .double_lock_condition(dl),
        .req(req), .rdata(rdata), .ack(ack), .err(err));

    // ****************************************************
    // helpers
    // ****************************************************
    function automatic logic [31:0] ew(input pmsnap_pkg::pmsnap_live_s s, input logic n,
        input logic [11:0] a);
        case (a)
            pmsnap_pkg::OFF_PC_LO: return s.pc.addr[31:0];
            pmsnap_pkg::OFF_PC_HI: return {s.pc.world, 7'h00, s.pc.addr[55:32]};
            pmsnap_pkg::OFF_CTX_EL1: return s.ctx_el1;
            pmsnap_pkg::OFF_CTX_EL2: return s.ctx_el2;
            pmsnap_pkg::OFF_STATUS: return {31'h0, n};
            pmsnap_pkg::OFF_OVF: return s.ovf;
            pmsnap_pkg::OFF_CYC_LO: return s.cyc[31:0];
            pmsnap_pkg::OFF_CYC_HI: return s.cyc[63:32];
            default: return s.evt[(a - 12'h620) * 8 +: 32];
        endcase
    endfunction

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one request, answer checked one edge later
    task automatic acc(input logic wr, input logic [11:0] a, input logic [31:0] wd,
        input logic [31:0] exp, input logic e);
        req = '{1'b1, wr, a, wd};
        @(posedge sys_clk);
        #1;
        check({31'h0, ack}, 32'h1);
        check({31'h0, err}, {31'h0, e});
        check(rdata, exp);
    endtask

    task automatic rnd_live();
        logic [415:0] t;
        for (int i = 0; i < 13; i++) t[i*32 +: 32] = $random(seed);
        live = t[$bits(live)-1:0];
    endtask

    // every word read, then a write that must be ignored
    task automatic readall();
        for (logic [11:0] a = 12'h600; a < 12'h638; a += 12'h004) begin
            acc(1'b0, a, 32'h0, ew(cap, nc, a), 1'b0);
            acc(1'b1, a, $random(seed), 32'h0, 1'b0);
        end
    endtask

    task automatic end_of_test();
        if (failures == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // ****************************************************
    // clock and sequence
    // ****************************************************
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    initial begin
        seed = 32'ha993cf7b;
        failures = 0;
        n_compared = 0;
        {resetn, go, sec_v, pwr, dl} = 5'h00;
        req = '0;
        live = '0;
        cap = '0;
        nc = 1'b1;
        repeat (8) @(posedge sys_clk);
        #1 resetn = 1'b1;
        readall();
        // trigger captures, some under security violation
        for (int k = 0; k < 6; k++) begin
            rnd_live();
            sec_v = k[0];
            acc(1'b1, 12'h6f0, $random(seed) | 32'h1, 32'h0, 1'b0);
            cap = sec_v ? {live[$bits(live)-1:192], cap.evt} : live;
            nc = sec_v;
            sec_v = 1'b0;
            rnd_live();
            readall();
            acc(1'b1, 12'h6f0, $random(seed) & 32'hfffffffe, 32'h0, 1'b0);
            readall();
        end
        // blocked by power or double lock
        for (int j = 0; j < 2; j++) begin
            {pwr, dl} = 2'h1 << j;
            acc(1'b1, 12'h6f0, 32'h1, 32'h0, 1'b1);
            acc(1'b0, 12'h610, 32'h0, 32'h0, 1'b1);
        end
        {pwr, dl} = 2'h0;
        acc(1'b0, 12'h6f4, 32'h0, 32'h0, 1'b1);
        acc(1'b0, 12'h6f0, 32'h0, 32'h0, 1'b0);
        readall();
        // debugger pin capture
        req.en = 1'b0;
        rnd_live();
        go = 1'b1;
        repeat (6) @(posedge sys_clk);
        #1 go = 1'b0;
        cap = live;
        nc = 1'b0;
        rnd_live();
        readall();
        check({24'h0, dbg.n_req_r}, 32'h1);
        end_of_test();
    end
endmodule

// [bench/pmsnap_dbg.sv]
`timescale 1ns/1ps

// ****************************************************
// external debugger model
// ****************************************************
module pmsnap_dbg (
    input wire logic sys_clk,
    input wire logic go,
    output logic ext_req_pin = 1'b0
);
    logic [7:0] n_req_r = 8'h00;
    // request level follows the command one edge later
    always_ff @(posedge sys_clk) begin
        ext_req_pin <= go;
    end
    // own tally of attempted captures
    always_ff @(posedge sys_clk) begin
        if (go && !ext_req_pin) begin
            n_req_r <= n_req_r + 8'h01;
        end
    end
endmodule

// [common/pmsnap_pkg.sv]
package pmsnap_pkg;

    // ****************************************************
    // register offsets
    // ****************************************************
    localparam logic [11:0] OFF_PC_LO = 12'h600;
    localparam logic [11:0] OFF_PC_HI = 12'h604;
    localparam logic [11:0] OFF_CTX_EL1 = 12'h608;
    localparam logic [11:0] OFF_CTX_EL2 = 12'h60c;
    localparam logic [11:0] OFF_STATUS = 12'h610;
    localparam logic [11:0] OFF_OVF = 12'h614;
    localparam logic [11:0] OFF_CYC_LO = 12'h618;
    localparam logic [11:0] OFF_CYC_HI = 12'h61c;
    localparam logic [11:0] OFF_EVT_BASE = 12'h620;
    localparam logic [11:0] OFF_TRIGGER = 12'h6f0;

    // ****************************************************
    // field positions and reset values
    // ****************************************************
    localparam int PC_WORLD_BIT = 63;
    localparam int PC_ADDR_MSB = 55;
    localparam int STATUS_NC_BIT = 0;
    localparam int TRIGGER_BIT = 0;
    localparam logic STATUS_NC_RESET = 1'b1;
    localparam int NUM_EVT = 6;

    // ****************************************************
    // carriers
    // ****************************************************
    typedef struct packed {
        logic world;
        logic [55:0] addr;
    } pmsnap_pc_s;

    typedef struct packed {
        pmsnap_pc_s pc;
        logic [31:0] ctx_el1;
        logic [31:0] ctx_el2;
        logic [31:0] ovf;
        logic [63:0] cyc;
        logic [NUM_EVT*32-1:0] evt;
    } pmsnap_live_s;

    typedef struct packed {
        logic en;
        logic wr;
        logic [11:0] addr;
        logic [31:0] wdata;
    } pmsnap_req_s;

endpackage

// [hdl/pmsnap_bank.sv]
`timescale 1ns/1ps

// How it works
// R1: snapshot words live from offset 0x600
// R2: each debugger request takes fresh snapshot
// R3: pc snapshot loads live sample, reads inert
// R4: pc bit63 world, 62:56 zero, 55:0 address
// R5: copy el1 context sample at capture
// R6: copy el2 context sample at capture
// R7: status bit0 zero means counters captured
// R8: security violation skips event counters, flags
// R9: status ignores pc snapshot outcome
// R10: status resets to one, first capture overwrites
// R11: monitor tracks its own capture success
// R12: overflow copy ignores later set/clear writes
// R13: cycle copy in low/high words, frozen
// R14: six event copies at base plus four n
// R15: event copies ignore later counter writes
// R16: write-only trigger word at 0x6f0
// R17: bit0 one captures now, zero ignored
// R18: error while powered down or double-locked
// R19: all copies load in one cycle; event copies are skipped under security violation
module pmsnap_bank #(
    parameter int NUM_EVT = pmsnap_pkg::NUM_EVT
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic ce,
    input wire logic ext_req_pin,
    input wire pmsnap_pkg::pmsnap_live_s live,
    input wire logic sec_violation,
    input wire logic core_pwr_off,
    input wire logic double_lock_condition,
    input wire pmsnap_pkg::pmsnap_req_s req,
    output logic [31:0] rdata,
    output logic ack,
    output logic err
);

    initial begin
        if (NUM_EVT != pmsnap_pkg::NUM_EVT) begin
            $error("event counter count must match live carrier");
        end
    end

    // ****************************************************
    // storage
    // ****************************************************
    pmsnap_pkg::pmsnap_live_s snap_r;
    logic nc_r;
    logic [31:0] rdata_nxt;
    logic err_nxt;
    logic hit;
    logic blocked;
    logic sw_req;
    logic capture;

    // access refused while core off or locked
    assign blocked = core_pwr_off | double_lock_condition; // R18

    // software trigger: bit0 set on an allowed write
    assign sw_req = ce & req.en & req.wr & ~blocked & (req.addr == pmsnap_pkg::OFF_TRIGGER)
                    & req.wdata[pmsnap_pkg::TRIGGER_BIT]; // R16 R17

    pmsnap_trig u_trig (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .ce(ce),
        .ext_req_pin(ext_req_pin),
        .sw_req(sw_req),
        .capture(capture)
    );

    // ****************************************************
    // capture of the copies in one cycle, event copies only without security violation
    // ****************************************************
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            snap_r <= '0;
        end else if (ce && capture) begin // R2 R19
            snap_r.pc <= live.pc; // R3
            snap_r.ctx_el1 <= live.ctx_el1; // R5
            snap_r.ctx_el2 <= live.ctx_el2; // R6
            snap_r.ovf <= live.ovf; // R12
            snap_r.cyc <= live.cyc; // R13
            if (!sec_violation) begin
                snap_r.evt <= live.evt; // R8 R15
            end
        end
    end

    // no-capture flag, counters only
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            nc_r <= pmsnap_pkg::STATUS_NC_RESET; // R10
        end else if (ce && capture) begin
            nc_r <= sec_violation; // R7 R8 R9
        end
    end

    // ****************************************************
    // read decode
    // ****************************************************
    always_comb begin
        hit = 1'b1;
        rdata_nxt = 32'h0;
        unique case (req.addr)
            pmsnap_pkg::OFF_PC_LO: rdata_nxt = snap_r.pc.addr[31:0];
            pmsnap_pkg::OFF_PC_HI: rdata_nxt = {snap_r.pc.world, 7'h00,
                                                snap_r.pc.addr[55:32]}; // R4
            pmsnap_pkg::OFF_CTX_EL1: rdata_nxt = snap_r.ctx_el1;
            pmsnap_pkg::OFF_CTX_EL2: rdata_nxt = snap_r.ctx_el2;
            pmsnap_pkg::OFF_STATUS: rdata_nxt = {31'h0, nc_r}; // R7
            pmsnap_pkg::OFF_OVF: rdata_nxt = snap_r.ovf;
            pmsnap_pkg::OFF_CYC_LO: rdata_nxt = snap_r.cyc[31:0]; // R13
            pmsnap_pkg::OFF_CYC_HI: rdata_nxt = snap_r.cyc[63:32];
            pmsnap_pkg::OFF_TRIGGER: rdata_nxt = 32'h0;
            default: begin
                hit = 1'b0;
                for (int i = 0; i < NUM_EVT; i++) begin
                    if (req.addr == pmsnap_pkg::OFF_EVT_BASE + 12'(4 * i)) begin // R14
                        hit = 1'b1;
                        rdata_nxt = snap_r.evt[i*32 +: 32];
                    end
                end
            end
        endcase
        err_nxt = blocked | ~hit; // R1 R18
    end

    // one-cycle answer, reads never touch live sampling
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            rdata <= 32'h0;
            ack <= 1'b0;
            err <= 1'b0;
        end else if (ce) begin
            ack <= req.en;
            err <= req.en & err_nxt;
            rdata <= (req.en && !req.wr && !err_nxt) ? rdata_nxt : 32'h0; // R3
        end
    end

    // ****************************************************
    // checks
    // ****************************************************
    a_status_reset: assert property (@(posedge sys_clk) $rose(resetn) |-> nc_r) // R10
        else $error("status not one after reset");
    a_blocked_err: assert property (@(posedge sys_clk) disable iff (!resetn)
        ce && req.en && blocked |=> err && ack) // R18
        else $error("blocked access not refused");
    a_nc_follows: assert property (@(posedge sys_clk) disable iff (!resetn)
        ce && capture |=> nc_r == $past(sec_violation)) // R7
        else $error("status not capture outcome");
    a_evt_hold: assert property (@(posedge sys_clk) disable iff (!resetn)
        ce && capture && sec_violation |=> $stable(snap_r.evt)) // R8
        else $error("event copy changed on violation");
    a_cyc_load: assert property (@(posedge sys_clk) disable iff (!resetn)
        ce && capture |=> snap_r.cyc == $past(live.cyc)) // R13
        else $error("cycle copy not loaded");
    a_pc_load: assert property (@(posedge sys_clk) disable iff (!resetn)
        ce && capture |=> snap_r.pc == $past(live.pc) && snap_r.ovf == $past(live.ovf)) // R3
        else $error("pc or overflow copy not loaded");
    a_hold_idle: assert property (@(posedge sys_clk) disable iff (!resetn)
        !capture |=> $stable(snap_r)) // R15
        else $error("copy changed without capture");
    a_ctx_load: assert property (@(posedge sys_clk) disable iff (!resetn)
        ce && capture |=> snap_r.ctx_el1 == $past(live.ctx_el1)
                          && snap_r.ctx_el2 == $past(live.ctx_el2)) // R5
        else $error("context copy not loaded");
    a_sw_trigger: assert property (@(posedge sys_clk) disable iff (!resetn)
        sw_req |=> snap_r.cyc == $past(live.cyc)) // R17
        else $error("software trigger missed");

endmodule

// [hdl/pmsnap_trig.sv]
`timescale 1ns/1ps

// ****************************************************
// capture request merge
// ****************************************************
module pmsnap_trig (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic ce,
    input wire logic ext_req_pin,
    input wire logic sw_req,
    output logic capture
);

    logic sync1_r;
    logic sync2_r;
    logic sync3_r;

    // pin synchroniser plus edge memory
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
            sync3_r <= 1'b0;
        end else if (ce) begin
            sync1_r <= ext_req_pin;
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
        end
    end

    // rising edge of the pin or software write
    assign capture = (sync2_r & ~sync3_r) | sw_req;

endmodule
